// file: common/bfs_pkg.sv
// Shared constants and carrier types for the bus fault status bank.
`default_nettype none

package bfs_pkg;

	// ---------------------------------------------------------------
	// Register command codes and reset values
	// ---------------------------------------------------------------
	localparam int unsigned BFS_DATA_W         = 8;
	localparam logic [7:0]  BFS_CMD_BUS_LIMIT  = 8'hd7;
	localparam logic [7:0]  BFS_CMD_SHORT      = 8'hd8;
	localparam logic [7:0]  BFS_CMD_PHASE      = 8'hd9;
	localparam logic [7:0]  BFS_RESET_VALUE    = 8'h00;
	localparam logic [7:0]  BFS_READ_IDLE      = 8'h00;

	// ---------------------------------------------------------------
	// Field layouts
	// ---------------------------------------------------------------
	localparam int unsigned BFS_LIMIT_N        = 8;
	localparam int unsigned BFS_SHORT_N        = 5;
	localparam int unsigned BFS_PHASE_N        = 6;
	localparam int unsigned BFS_LV_OUT_OV      = 0;
	localparam int unsigned BFS_LV_OUT_UV      = 1;
	localparam int unsigned BFS_LV_IN_OV       = 2;
	localparam int unsigned BFS_LV_IN_UV       = 3;
	localparam int unsigned BFS_HV_OUT_OV      = 4;
	localparam int unsigned BFS_HV_OUT_UV      = 5;
	localparam int unsigned BFS_HV_IN_OV       = 6;
	localparam int unsigned BFS_HV_IN_UV       = 7;
	localparam int unsigned BFS_SC_HIGH_SIDE   = 0;
	localparam int unsigned BFS_SC_LV_BUS      = 1;
	localparam int unsigned BFS_SC_LOW_SIDE    = 2;
	localparam int unsigned BFS_SC_HV_BUS      = 3;
	localparam int unsigned BFS_SC_FLYBACK     = 4;
	localparam logic [7:0]  BFS_BUCK_LIMITS    = 8'h43;
	localparam logic [7:0]  BFS_BOOST_LIMITS   = 8'hbc;
	localparam logic [7:0]  BFS_SHORT_MASK     = 8'h1f;
	localparam logic [7:0]  BFS_PHASE_MASK     = 8'h3f;
	localparam logic        BFS_DIR_BUCK       = 1'b0;
	localparam logic        BFS_DIR_BOOST      = 1'b1;

	// ---------------------------------------------------------------
	// Carrier types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic                   direction;
		logic [BFS_LIMIT_N-1:0] bus_limit;
		logic [BFS_SHORT_N-1:0] short_det;
		logic [BFS_PHASE_N-1:0] first_level_overcurrent;
		logic [BFS_PHASE_N-1:0] negative_overcurrent;
	} bfs_pins_s;

	localparam int unsigned BFS_PINS_W = $bits(bfs_pins_s);

	typedef struct packed {
		logic [7:0]            cmd;
		logic                  wr;
		logic                  rd;
		logic [BFS_DATA_W-1:0] wdata;
	} bfs_req_s;

	typedef struct packed {
		logic                  ack;
		logic                  unmapped;
		logic [BFS_DATA_W-1:0] rdata;
	} bfs_rsp_s;

endpackage : bfs_pkg

`default_nettype wire

// file: logic/bfs_pin_sync.sv
// Two-stage synchroniser for the fault detector and direction pins.
`timescale 1ns/1ns
`default_nettype none

module bfs_pin_sync (
	input  wire logic               i_clk,
	input  wire logic               i_srst,
	input  wire bfs_pkg::bfs_pins_s i_pins,
	output var  bfs_pkg::bfs_pins_s o_pins
);
	import bfs_pkg::*;

	typedef struct packed {
		bfs_pins_s meta;
		bfs_pins_s stable;
	} bfs_sync_s;

	bfs_sync_s st;
	bfs_sync_s next_st;

	// ---------------------------------------------------------------
	// Stage chain
	// ---------------------------------------------------------------
	// The first stage feeds only the second; nothing else may look at it.
	always_comb begin
		next_st        = st;
		next_st.meta   = i_pins;
		next_st.stable = st.meta;
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_pins = st.stable;

endmodule : bfs_pin_sync

`default_nettype wire

// file: logic/bfs_fault_status_bank.sv
// Sticky fault status bank: bus limits, potential shorts, overcurrent phase location.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// [R01] Buck mode: low-voltage bus output overvoltage sets bus-limit bit 0.
// [R02] Buck mode: low-voltage bus output undervoltage sets bus-limit bit 1.
// [R03] Boost mode: low-voltage bus input overvoltage sets bus-limit bit 2.
// [R04] Boost mode: low-voltage bus input undervoltage sets bus-limit bit 3.
// [R05] Boost mode: high-voltage bus output overvoltage sets bus-limit bit 4.
// [R06] Boost mode: high-voltage bus output undervoltage sets bus-limit bit 5.
// [R07] Buck mode: high-voltage bus input overvoltage sets bus-limit bit 6.
// [R08] Boost mode: high-voltage bus input undervoltage sets bus-limit bit 7.
// [R09] Possible high-side switch short sets short register bit 0.
// [R10] Possible low-voltage bus short to ground sets short register bit 1.
// [R11] Possible low-side switch short sets short register bit 2.
// [R12] Possible high-voltage bus short to ground sets short register bit 3.
// [R13] Possible flyback switch short sets bit 4; bits 7 to 5 reserved.
// [R14] Overcurrent or negative overcurrent at phase n sets phase bit n-1.
// [R15] Host reads phase register after an overcurrent summary flag rises.
// [R16] Direction pin reported as status: 0 buck, 1 boost; selects bus-limit flags.
// [R17] Flags stay set until software writes 0; all start at zero.
module bfs_fault_status_bank (
	input  wire logic               i_clk,
	input  wire logic               i_srst,
	input  wire bfs_pkg::bfs_req_s  i_req,
	input  wire bfs_pkg::bfs_pins_s i_pins,
	output var  bfs_pkg::bfs_rsp_s  o_rsp,
	output var  logic               o_boost_mode
);
	import bfs_pkg::*;

	typedef struct packed {
		logic [7:0] bus_limit;
		logic [7:0] short_flags;
		logic [7:0] phase_loc;
		bfs_rsp_s   rsp;
		logic       boost;
	} bfs_state_s;

	bfs_state_s st;
	bfs_state_s next_st;
	bfs_pins_s  sp;
	logic [7:0] limit_set;
	logic [7:0] short_set;
	logic [7:0] phase_set;
	logic       hit_limit;
	logic       hit_short;
	logic       hit_phase;

	// ---------------------------------------------------------------
	// Pin synchronisation
	// ---------------------------------------------------------------
	bfs_pin_sync u_sync (
		.i_clk  (i_clk),
		.i_srst (i_srst),
		.i_pins (i_pins),
		.o_pins (sp)
	);

	// ---------------------------------------------------------------
	// Set terms
	// ---------------------------------------------------------------
	// A bus-limit detector only counts in the direction where that bus side
	// is the one being limited; the other direction's flags are masked so stale detector
	// levels from the idle direction cannot raise a misleading flag.
	always_comb begin
		if (sp.direction == BFS_DIR_BOOST) begin
			limit_set = sp.bus_limit & BFS_BOOST_LIMITS; // R03 R04 R05 R06 R08
		end else begin
			limit_set = sp.bus_limit & BFS_BUCK_LIMITS; // R01 R02 R07
		end
	end

	always_comb begin
		short_set              = 8'h00;
		short_set[BFS_SHORT_N-1:0] = sp.short_det; // R09 R10 R11 R12 R13
	end

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_phase
			if (g < BFS_PHASE_N) begin : g_live
				// Either condition marks the phase; which one is not kept.
				assign phase_set[g] = sp.first_level_overcurrent[g]
					| sp.negative_overcurrent[g]; // R14
			end else begin : g_resv
				assign phase_set[g] = 1'b0;
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Command decode and register update
	// ---------------------------------------------------------------
	assign hit_limit = (i_req.cmd == BFS_CMD_BUS_LIMIT);
	assign hit_short = (i_req.cmd == BFS_CMD_SHORT);
	assign hit_phase = (i_req.cmd == BFS_CMD_PHASE);

	always_comb begin
		next_st = st;
		// Hardware set is ORed after the write so an event in the clearing
		// cycle survives.
		if (i_req.wr && hit_limit) begin
			next_st.bus_limit = i_req.wdata; // R17
		end
		next_st.bus_limit = next_st.bus_limit | limit_set;
		if (i_req.wr && hit_short) begin
			next_st.short_flags = i_req.wdata; // R17
		end
		next_st.short_flags = (next_st.short_flags | short_set) & BFS_SHORT_MASK;
		if (i_req.wr && hit_phase) begin
			next_st.phase_loc = i_req.wdata; // R17
		end
		next_st.phase_loc = (next_st.phase_loc | phase_set) & BFS_PHASE_MASK;
		next_st.boost = sp.direction; // R16
		next_st.rsp.ack = i_req.rd | i_req.wr;
		next_st.rsp.unmapped = (i_req.rd | i_req.wr) & ~(hit_limit | hit_short | hit_phase);
		next_st.rsp.rdata = BFS_READ_IDLE;
		if (i_req.rd) begin
			case (1'b1)
				hit_limit: next_st.rsp.rdata = st.bus_limit;
				hit_short: next_st.rsp.rdata = st.short_flags;
				hit_phase: next_st.rsp.rdata = st.phase_loc; // R15
				default:   next_st.rsp.rdata = BFS_READ_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st.bus_limit   <= BFS_RESET_VALUE; // R17
			st.short_flags <= BFS_RESET_VALUE;
			st.phase_loc   <= BFS_RESET_VALUE;
			st.rsp         <= '0;
			st.boost       <= BFS_DIR_BUCK;
		end else begin
			st <= next_st;
		end
	end

	assign o_rsp        = st.rsp;
	assign o_boost_mode = st.boost;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	logic no_limit_wr;
	logic no_short_wr;
	logic no_phase_wr;
	assign no_limit_wr = !(i_req.wr && hit_limit);
	assign no_short_wr = !(i_req.wr && hit_short);
	assign no_phase_wr = !(i_req.wr && hit_phase);

	sequence s_buck_lv_out_ov;
		!sp.direction && sp.bus_limit[BFS_LV_OUT_OV];
	endsequence

	property p_buck_lv_ov;
		s_buck_lv_out_ov |=> st.bus_limit[BFS_LV_OUT_OV];
	endproperty
	a_buck_lv_ov: assert property (p_buck_lv_ov) // R01
		else $error("low bus output overvoltage flag not set in buck mode");

	property p_buck_lv_uv;
		(!sp.direction && sp.bus_limit[BFS_LV_OUT_UV]) |=> st.bus_limit[BFS_LV_OUT_UV];
	endproperty
	a_buck_lv_uv: assert property (p_buck_lv_uv) // R02
		else $error("low bus output undervoltage flag not set in buck mode");

	property p_boost_gates_buck_bits;
		(sp.direction && no_limit_wr && !st.bus_limit[BFS_LV_OUT_OV])
			|=> !st.bus_limit[BFS_LV_OUT_OV];
	endproperty
	a_boost_gates_buck_bits: assert property (p_boost_gates_buck_bits) // R01
		else $error("buck-only flag raised while in boost mode");

	property p_boost_lv_in;
		(sp.direction && sp.bus_limit[BFS_LV_IN_OV] && sp.bus_limit[BFS_LV_IN_UV])
			|=> (st.bus_limit[BFS_LV_IN_OV] && st.bus_limit[BFS_LV_IN_UV]);
	endproperty
	a_boost_lv_in: assert property (p_boost_lv_in) // R03
		else $error("low bus input limit flags not set in boost mode");

	property p_buck_gates_boost_bits;
		(!sp.direction && no_limit_wr && !st.bus_limit[BFS_HV_OUT_OV]
			&& !st.bus_limit[BFS_HV_IN_UV]) |=> (!st.bus_limit[BFS_HV_OUT_OV]
			&& !st.bus_limit[BFS_HV_IN_UV]);
	endproperty
	a_buck_gates_boost_bits: assert property (p_buck_gates_boost_bits) // R05
		else $error("boost-only flag raised while in buck mode");

	property p_hv_flags;
		(sp.direction && sp.bus_limit[BFS_HV_OUT_UV]) |=> st.bus_limit[BFS_HV_OUT_UV];
	endproperty
	a_hv_flags: assert property (p_hv_flags) // R06
		else $error("high bus output undervoltage flag not set in boost mode");

	property p_hv_in_ov_buck;
		(!sp.direction && sp.bus_limit[BFS_HV_IN_OV]) |=> st.bus_limit[BFS_HV_IN_OV];
	endproperty
	a_hv_in_ov_buck: assert property (p_hv_in_ov_buck) // R07
		else $error("high bus input overvoltage flag not set in buck mode");

	property p_hv_in_uv_boost;
		(sp.direction && sp.bus_limit[BFS_HV_IN_UV]) |=> st.bus_limit[BFS_HV_IN_UV];
	endproperty
	a_hv_in_uv_boost: assert property (p_hv_in_uv_boost) // R08
		else $error("high bus input undervoltage flag not set in boost mode");

	property p_short_bits;
		(sp.short_det != '0) |=>
			((st.short_flags[BFS_SHORT_N-1:0] & $past(sp.short_det)) == $past(sp.short_det));
	endproperty
	a_short_bits: assert property (p_short_bits) // R09 R10 R11 R12
		else $error("short flag not set by its detector");

	property p_short_set;
		sp.short_det[BFS_SC_FLYBACK] |=> st.short_flags[BFS_SC_FLYBACK];
	endproperty
	a_short_set: assert property (p_short_set) // R13
		else $error("flyback short flag not set");

	property p_short_reserved;
		st.short_flags[7:BFS_SHORT_N] == 3'b000;
	endproperty
	a_short_reserved: assert property (p_short_reserved) // R13
		else $error("reserved short register bits not zero");

	property p_phase_set;
		(sp.first_level_overcurrent != '0) |=>
			((st.phase_loc[BFS_PHASE_N-1:0] & $past(sp.first_level_overcurrent))
			== $past(sp.first_level_overcurrent));
	endproperty
	a_phase_set: assert property (p_phase_set) // R14
		else $error("phase location flag not set by first-level overcurrent");

	property p_phase_set_neg;
		(sp.negative_overcurrent != '0) |=>
			((st.phase_loc[BFS_PHASE_N-1:0] & $past(sp.negative_overcurrent))
			== $past(sp.negative_overcurrent));
	endproperty
	a_phase_set_neg: assert property (p_phase_set_neg) // R14
		else $error("phase location flag not set by negative overcurrent");

	property p_phase_reserved;
		st.phase_loc[7:BFS_PHASE_N] == 2'b00;
	endproperty
	a_phase_reserved: assert property (p_phase_reserved) // R14
		else $error("reserved phase register bits not zero");

	property p_sticky;
		(st.short_flags[BFS_SC_HIGH_SIDE] && no_short_wr)
			|=> st.short_flags[BFS_SC_HIGH_SIDE];
	endproperty
	a_sticky: assert property (p_sticky) // R17
		else $error("short flag dropped without a clearing write");

	property p_clear;
		(i_req.wr && hit_phase && i_req.wdata == 8'h00 && phase_set == 8'h00)
			|=> st.phase_loc == 8'h00;
	endproperty
	a_clear: assert property (p_clear) // R17
		else $error("phase register not cleared by a zero write");

	property p_set_beats_clear;
		(i_req.wr && hit_short && !i_req.wdata[BFS_SC_LV_BUS] && sp.short_det[BFS_SC_LV_BUS])
			|=> st.short_flags[BFS_SC_LV_BUS];
	endproperty
	a_set_beats_clear: assert property (p_set_beats_clear) // R17
		else $error("event lost in the clearing cycle");

	property p_direction;
		##1 o_boost_mode == $past(sp.direction);
	endproperty
	a_direction: assert property (p_direction) // R16
		else $error("direction status does not follow the pin");

	property p_read;
		(i_req.rd && hit_limit) |=> (o_rsp.ack && o_rsp.rdata == $past(st.bus_limit));
	endproperty
	a_read: assert property (p_read)
		else $error("read answer wrong or late");

	property p_unmapped;
		(i_req.rd && !hit_limit && !hit_short && !hit_phase)
			|=> (o_rsp.unmapped && o_rsp.rdata == 8'h00);
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not flagged");

	property p_no_unsolicited;
		!(i_req.rd || i_req.wr) |=> !o_rsp.ack;
	endproperty
	a_no_unsolicited: assert property (p_no_unsolicited)
		else $error("answer without request");

	property p_hold_until_clear;
		(st.bus_limit[BFS_HV_IN_UV] && no_limit_wr) [*2] |=> st.bus_limit[BFS_HV_IN_UV];
	endproperty
	a_hold_until_clear: assert property (p_hold_until_clear) // R08
		else $error("high bus input undervoltage flag dropped on its own");

endmodule : bfs_fault_status_bank

`default_nettype wire

// file: verification/bfs_fault_status_bank_tb_top.sv
// Self-checking testbench for the bus fault status bank.
`timescale 1ns/1ns
`default_nettype none

module bfs_fault_status_bank_tb_top;
	import bfs_pkg::*;

	logic       i_clk;
	logic       i_srst;
	bfs_req_s   i_req;
	bfs_pins_s  i_pins;
	bfs_rsp_s   o_rsp;
	logic       o_boost_mode;
	bfs_pins_s  pins;
	logic       dir;
	logic [7:0] exp_lim;
	logic [8:0] exp_q[$];
	int         bad_count;
	int         total_checks;

	bfs_fault_status_bank DUT (
		.i_clk        (i_clk),
		.i_srst       (i_srst),
		.i_req        (i_req),
		.i_pins       (i_pins),
		.o_rsp        (o_rsp),
		.o_boost_mode (o_boost_mode)
	);

	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic test_done();
		$display("checks=%0d mismatches=%0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : test_done

	// One strobe cycle per access; writes answer with idle read data.
	task automatic access(input logic [7:0] cmd, input logic wr, input logic [7:0] wdata,
		input logic [7:0] exp);
		logic unm;
		unm = !(cmd inside {BFS_CMD_BUS_LIMIT, BFS_CMD_SHORT, BFS_CMD_PHASE});
		@(negedge i_clk);
		exp_q.push_back({unm, wr ? BFS_READ_IDLE : exp});
		i_req = '{cmd: cmd, wr: wr, rd: !wr, wdata: wdata};
		@(negedge i_clk);
		i_req = '0;
	endtask : access

	// Detectors held for three cycles, then dropped long enough to leave the synchroniser.
	task automatic pulse(input bfs_pins_s p);
		@(negedge i_clk);
		i_pins = p;
		repeat (3) @(negedge i_clk);
		i_pins = p & {1'b1, {(BFS_PINS_W-1){1'b0}}};
		repeat (4) @(negedge i_clk);
	endtask : pulse

	task automatic set_dir(input logic d);
		@(negedge i_clk);
		i_pins.direction = d;
		repeat (4) @(negedge i_clk);
		chk({8'h00, o_boost_mode}, {8'h00, d});
	endtask : set_dir

	// Answers are checked in order of request, half a cycle after they land.
	always @(negedge i_clk) begin
		if (o_rsp.ack === 1'b1)
			chk({o_rsp.unmapped, o_rsp.rdata}, exp_q.size() > 0 ? exp_q.pop_front() : 9'h1ff);
	end

	initial begin
		#20000;
		bad_count++;
		$display("watchdog expired");
		test_done();
	end

	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		i_srst = 1'b1;
		i_req = '0;
		i_pins = '0;
		bad_count = 0;
		total_checks = 0;
		void'($urandom(32'h373e));
		repeat (10) @(negedge i_clk);
		i_srst = 1'b0;
		repeat (3) @(negedge i_clk);
		access(BFS_CMD_BUS_LIMIT, 1'b0, 8'h00, BFS_RESET_VALUE);
		access(BFS_CMD_SHORT, 1'b0, 8'h00, BFS_RESET_VALUE);
		access(BFS_CMD_PHASE, 1'b0, 8'h00, BFS_RESET_VALUE);
		access(8'hda, 1'b1, 8'hff, 8'h00);
		access(8'hda, 1'b0, 8'h00, 8'h00);
		access(BFS_CMD_BUS_LIMIT, 1'b1, 8'h5a, 8'h00);
		access(BFS_CMD_BUS_LIMIT, 1'b0, 8'h00, 8'h5a);
		access(BFS_CMD_BUS_LIMIT, 1'b1, 8'h00, 8'h00);
		$display("test reset_and_access done");

		// Every limit detector raised: only the flags of the current mode latch and stay.
		for (int d = 0; d < 2; d++) begin
			set_dir(d[0]);
			pins = i_pins;
			pins.bus_limit = 8'hff;
			pulse(pins);
			exp_lim = d ? BFS_BOOST_LIMITS : BFS_BUCK_LIMITS;
			access(BFS_CMD_BUS_LIMIT, 1'b0, 8'h00, exp_lim);
			access(BFS_CMD_BUS_LIMIT, 1'b1, 8'h00, 8'h00);
			access(BFS_CMD_BUS_LIMIT, 1'b0, 8'h00, 8'h00);
		end
		$display("test mode_gating done");

		for (int i = 0; i < BFS_SHORT_N; i++) begin
			pins = i_pins;
			pins.short_det = 5'(1 << i);
			pulse(pins);
			access(BFS_CMD_SHORT, 1'b0, 8'h00, 8'(1 << i));
			access(BFS_CMD_SHORT, 1'b1, 8'h00, 8'h00);
		end
		access(BFS_CMD_SHORT, 1'b1, 8'hff, 8'h00);
		access(BFS_CMD_SHORT, 1'b0, 8'h00, BFS_SHORT_MASK);
		access(BFS_CMD_SHORT, 1'b1, 8'h00, 8'h00);
		// Detector still high while software clears: the set must survive the write.
		pins = i_pins;
		pins.short_det = 5'(1 << BFS_SC_LV_BUS);
		@(negedge i_clk);
		i_pins = pins;
		repeat (3) @(negedge i_clk);
		access(BFS_CMD_SHORT, 1'b1, 8'h00, 8'h00);
		access(BFS_CMD_SHORT, 1'b0, 8'h00, 8'(1 << BFS_SC_LV_BUS));
		pulse(pins & {1'b1, {(BFS_PINS_W-1){1'b0}}});
		access(BFS_CMD_SHORT, 1'b1, 8'h00, 8'h00);
		access(BFS_CMD_SHORT, 1'b0, 8'h00, 8'h00);
		$display("test short_flags done");

		// Either overcurrent kind must land on the same phase bit.
		for (int n = 0; n < BFS_PHASE_N; n++) begin
			pins = i_pins;
			if ($urandom_range(1) == 1) pins.first_level_overcurrent = 6'(1 << n);
			else pins.negative_overcurrent = 6'(1 << n);
			pulse(pins);
			access(BFS_CMD_PHASE, 1'b0, 8'h00, 8'(1 << n));
			access(BFS_CMD_PHASE, 1'b1, 8'h00, 8'h00);
		end
		access(BFS_CMD_PHASE, 1'b1, 8'hff, 8'h00);
		access(BFS_CMD_PHASE, 1'b0, 8'h00, BFS_PHASE_MASK);
		access(BFS_CMD_PHASE, 1'b1, 8'h00, 8'h00);
		$display("test phase_location done");

		// A reset in mid-run must drop flags that are already set.
		pulse(pins);
		access(BFS_CMD_PHASE, 1'b0, 8'h00, 8'(1 << (BFS_PHASE_N - 1)));
		@(negedge i_clk);
		i_srst = 1'b1;
		repeat (2) @(negedge i_clk);
		i_srst = 1'b0;
		access(BFS_CMD_PHASE, 1'b0, 8'h00, BFS_RESET_VALUE);
		$display("test mid_reset done");

		for (int k = 0; k < 8; k++) begin
			dir = 1'($urandom_range(1));
			set_dir(dir);
			pins = i_pins;
			pins.bus_limit = 8'($urandom);
			pulse(pins);
			exp_lim = pins.bus_limit & (dir ? BFS_BOOST_LIMITS : BFS_BUCK_LIMITS);
			access(BFS_CMD_BUS_LIMIT, 1'b0, 8'h00, exp_lim);
			access(BFS_CMD_BUS_LIMIT, 1'b1, 8'h00, 8'h00);
		end
		$display("test random_limits done");

		repeat (4) @(negedge i_clk);
		chk(9'(exp_q.size()), 9'h000);
		test_done();
	end

endmodule : bfs_fault_status_bank_tb_top

`default_nettype wire
